// ---- core/ncr_nvm_channel_trigger_regs.sv ----
`timescale 1ns/1ns
`include "ncr_defines.svh"

// Summary of operation
// - writing 1 starts fault-dump NVM row read
// - writing 1 starts NVM program, self-clears
// - writing 1 reloads NVM into registers
// - channel trigger register at 21h, reset zero
// - PMBus page FFh command E5h selects it
// - compare-clear resets latched comparator outputs
// - margin-low bit issues margin-low, self-clears
// - margin-high bit issues margin-high, self-clears
// - function-start bit runs waveform while one
// - window outputs latched or transparent per setting
module ncr_nvm_channel_trigger_regs
  import ncr_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire ncr_acc_s access,
  input wire logic windowLatchEn,
  input wire logic [CHANNELS-1:0] cmpRawIn,
  input wire logic [CHANNELS-1:0] winRawIn,
  output logic [15:0] regRdata,
  output logic regRvalid,
  output logic faultRowReadGo,
  output logic nonvolProgramGo,
  output logic nonvolRestoreGo,
  output logic [CHANNELS-1:0] compareClear,
  output logic [CHANNELS-1:0] marginLowGo,
  output logic [CHANNELS-1:0] marginHighGo,
  output logic [CHANNELS-1:0] wavegenRun,
  output logic [CHANNELS-1:0] cmpFlag,
  output logic [CHANNELS-1:0] winCmp
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic pageOk;
  logic cmdChan;
  logic cmdTail;
  logic adrChan;
  logic adrTail;
  logic hitChan;
  logic hitTail;

  // compare page, command code and plain address once
  always_comb begin
    pageOk = (access.page == `NCR_PMB_PAGE);
    cmdChan = (access.addr == `NCR_PMB_CMD_CHAN_TRIG);
    cmdTail = (access.addr == `NCR_PMB_CMD_NVM_TAIL);
    adrChan = (access.addr == `NCR_ADDR_CHAN_TRIG);
    adrTail = (access.addr == `NCR_ADDR_NVM_TAIL);
  end

  // direct address or PMBus page plus command; on PMBus a foreign page hits nothing
  always_comb begin
    if (access.pmbus) begin
      hitChan = pageOk && cmdChan;
      hitTail = pageOk && cmdTail;
    end else begin
      hitChan = adrChan;
      hitTail = adrTail;
    end
  end

  // ----------------------------------------------------------------
  // access strobes
  // ----------------------------------------------------------------
  logic wrChan;
  logic wrTail;
  logic rdChan;
  logic rdTail;

  // qualify each hit with the kind of access
  always_comb begin
    wrChan = access.wr && hitChan;
    wrTail = access.wr && hitTail;
    rdChan = access.rd && hitChan;
    rdTail = access.rd && hitTail;
  end

  // ----------------------------------------------------------------
  // NVM trigger tail
  // ----------------------------------------------------------------
  logic [2:0] tailBits;
  logic [2:0] next_tailBits;

  // a 1 holds for exactly one cycle, a 0 starts nothing
  always_comb begin
    next_tailBits = `NCR_RST_NVM_TAIL;
    if (wrTail) begin
      next_tailBits = access.wdata[`NCR_BIT_ROW_READ:`NCR_BIT_RESTORE];
    end
  end

  // tail trigger flops, cleared again on the next edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tailBits <= `NCR_RST_NVM_TAIL;
    end else begin
      tailBits <= next_tailBits;
    end
  end

  // each stored bit is its own start pulse
  assign faultRowReadGo = tailBits[`NCR_BIT_ROW_READ];
  assign nonvolProgramGo = tailBits[`NCR_BIT_PROGRAM];
  assign nonvolRestoreGo = tailBits[`NCR_BIT_RESTORE];

  // ----------------------------------------------------------------
  // per-channel field slices
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] fldClear;
  logic [CHANNELS-1:0] fldLow;
  logic [CHANNELS-1:0] fldHigh;
  logic [CHANNELS-1:0] fldRun;

  // channel n takes the nibble n places down from the top
  for (genvar n = 0; n < CHANNELS; n++) begin : g_slice
    localparam int CH_BASE = `NCR_CH_TOP - `NCR_CH_STRIDE * n;
    assign fldClear[n] = access.wdata[CH_BASE - `NCR_FLD_CLEAR];
    assign fldLow[n] = access.wdata[CH_BASE - `NCR_FLD_LOW];
    assign fldHigh[n] = access.wdata[CH_BASE - `NCR_FLD_HIGH];
    assign fldRun[n] = access.wdata[CH_BASE - `NCR_FLD_RUN];
  end

  // ----------------------------------------------------------------
  // per-channel trigger pulses
  // ----------------------------------------------------------------
  ncr_chan_go_s chanGo;
  ncr_chan_go_s next_chanGo;

  // write-only bits pulse for one cycle, then fall back to zero
  always_comb begin
    next_chanGo = '0;
    if (wrChan) begin
      next_chanGo.clear = fldClear;
      next_chanGo.low = fldLow;
      next_chanGo.high = fldHigh;
    end
  end

  // pulse flops, self-clearing by construction
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      chanGo <= '0;
    end else begin
      chanGo <= next_chanGo;
    end
  end

  // pulse outputs leave straight from the pulse flops
  assign compareClear = chanGo.clear;
  assign marginLowGo = chanGo.low;
  assign marginHighGo = chanGo.high;

  // ----------------------------------------------------------------
  // function-start bits
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] next_wavegenRun;

  // run bits keep what was written until rewritten or reset
  always_comb begin
    next_wavegenRun = wavegenRun;
    if (wrChan) begin
      next_wavegenRun = fldRun;
    end
  end

  // run bit flops, zero after reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wavegenRun <= `NCR_RST_CHAN;
    end else begin
      wavegenRun <= next_wavegenRun;
    end
  end

  // ----------------------------------------------------------------
  // comparator inputs
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] cmpMeta;
  logic [CHANNELS-1:0] cmpSync;
  logic [CHANNELS-1:0] winMeta;
  logic [CHANNELS-1:0] winSync;
  logic [CHANNELS-1:0] next_cmpFlag;
  logic [CHANNELS-1:0] next_winCmp;

  // latching comparators are asynchronous: two flops each
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmpMeta <= `NCR_RST_CHAN;
      cmpSync <= `NCR_RST_CHAN;
    end else begin
      cmpMeta <= cmpRawIn;
      cmpSync <= cmpMeta;
    end
  end

  // window comparators are asynchronous: two flops each
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      winMeta <= `NCR_RST_CHAN;
      winSync <= `NCR_RST_CHAN;
    end else begin
      winMeta <= winRawIn;
      winSync <= winMeta;
    end
  end

  // ----------------------------------------------------------------
  // flag clear terms
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] cmpClr;
  logic [CHANNELS-1:0] winClr;

  // a clear pulse only takes effect while no set is seen
  always_comb begin
    cmpClr = chanGo.clear & ~cmpSync;
    winClr = chanGo.clear & ~winSync;
  end

  // latched comparator flag: a set wins over a clear in the same cycle
  always_comb begin
    next_cmpFlag = (cmpFlag & ~cmpClr) | cmpSync;
  end

  // comparator flag flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmpFlag <= `NCR_RST_CHAN;
    end else begin
      cmpFlag <= next_cmpFlag;
    end
  end

  // window output: latched with the set winning, or transparent to the input
  always_comb begin
    if (windowLatchEn) begin
      next_winCmp = (winCmp & ~winClr) | winSync;
    end else begin
      next_winCmp = winSync;
    end
  end

  // window output flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      winCmp <= `NCR_RST_CHAN;
    end else begin
      winCmp <= next_winCmp;
    end
  end

  // ----------------------------------------------------------------
  // read-back images
  // ----------------------------------------------------------------
  logic [15:0] chanImage;
  logic [15:0] tailImage;

  // run bits sit in their field; write-only bits always read zero
  always_comb begin
    chanImage = `NCR_RST_CHAN_TRIG;
    for (int n = 0; n < CHANNELS; n++) begin
      chanImage[`NCR_CH_TOP - `NCR_CH_STRIDE*n - `NCR_FLD_RUN] = wavegenRun[n];
    end
  end

  // the tail shows its pending trigger bits; upper bits read zero
  always_comb begin
    tailImage = '0;
    tailImage[`NCR_BIT_ROW_READ:`NCR_BIT_RESTORE] = tailBits;
  end

  // ----------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------
  logic [15:0] next_regRdata;

  // unmapped addresses and idle cycles read zero
  always_comb begin
    next_regRdata = `NCR_RST_CHAN_TRIG;
    if (rdChan) begin
      next_regRdata = chanImage;
    end else if (rdTail) begin
      next_regRdata = tailImage;
    end
  end

  // the answer stands for one cycle after every read, mapped or not
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      regRdata <= `NCR_RST_CHAN_TRIG;
      regRvalid <= 1'b0;
    end else begin
      regRdata <= next_regRdata;
      regRvalid <= access.rd;
    end
  end

endmodule : ncr_nvm_channel_trigger_regs

// ---- core/ncr_defines.svh ----
`ifndef NCR_DEFINES_SVH
`define NCR_DEFINES_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define NCR_ADDR_CHAN_TRIG 8'h21
`define NCR_ADDR_NVM_TAIL 8'h20
`define NCR_PMB_PAGE 8'hFF
`define NCR_PMB_CMD_CHAN_TRIG 8'hE5
`define NCR_PMB_CMD_NVM_TAIL 8'hE4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define NCR_RST_CHAN_TRIG 16'h0000
`define NCR_RST_NVM_TAIL 3'h0
`define NCR_RST_CHAN 4'h0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define NCR_BIT_RESTORE 0
`define NCR_BIT_PROGRAM 1
`define NCR_BIT_ROW_READ 2
`define NCR_CH_TOP 15
`define NCR_CH_STRIDE 4
`define NCR_FLD_CLEAR 0
`define NCR_FLD_LOW 1
`define NCR_FLD_HIGH 2
`define NCR_FLD_RUN 3

`endif

// ---- core/ncr_pkg.sv ----
package ncr_pkg;

  // one register access from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic pmbus;
    logic [7:0] page;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ncr_acc_s;

  // per-channel command pulses
  typedef struct packed {
    logic [3:0] clear;
    logic [3:0] low;
    logic [3:0] high;
  } ncr_chan_go_s;

endpackage : ncr_pkg

// ---- testbench/ncr_host_model.sv ----
`timescale 1ns/1ns
module ncr_host_model
  import ncr_pkg::*;
(
  input wire logic clk_sys,
  output ncr_acc_s access
);
  initial access = '0;
  // one access held for one edge, then released
  task automatic xfer(input logic w, input logic p, input logic [7:0] g, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    access <= '{wr: w, rd: !w, pmbus: p, page: g, addr: a, wdata: d};
    @(posedge clk_sys);
    access <= '0;
  endtask : xfer
endmodule : ncr_host_model

// ---- testbench/ncr_sva.sv ----
`timescale 1ns/1ns
module ncr_sva
  import ncr_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire ncr_acc_s access,
  input wire logic [15:0] regRdata,
  input wire logic regRvalid,
  input wire logic faultRowReadGo,
  input wire logic nonvolProgramGo,
  input wire logic nonvolRestoreGo,
  input wire logic [CHANNELS-1:0] compareClear,
  input wire logic [CHANNELS-1:0] marginLowGo,
  input wire logic [CHANNELS-1:0] marginHighGo,
  input wire logic [CHANNELS-1:0] wavegenRun
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // address decode and per-channel field slices
  wire logic pg = access.page == 8'hFF;
  wire logic chSel = access.pmbus ? pg && access.addr == 8'hE5 : access.addr == 8'h21;
  wire logic tHit = access.wr && (access.pmbus ? pg && access.addr == 8'hE4 : access.addr == 8'h20);
  wire logic chHit = access.wr && chSel;
  wire logic [15:0] w = access.wdata;
  sequence s_rd_ch;
    access.rd && chSel;
  endsequence
  chk_rd_valid: assert property (regRvalid == $past(access.rd)) else $error("read answer");
  chk_row_go: assert property (faultRowReadGo == $past(tHit && w[2])) else $error("row read");
  chk_prog_go: assert property (nonvolProgramGo == $past(tHit && w[1])) else $error("program");
  chk_restore_go: assert property (nonvolRestoreGo == $past(tHit && w[0])) else $error("reload");
  chk_clear_go: assert property (compareClear == $past(chHit ? {w[3], w[7], w[11], w[15]} : 4'h0))
    else $error("compare clear");
  chk_low_go: assert property (marginLowGo == $past(chHit ? {w[2], w[6], w[10], w[14]} : 4'h0))
    else $error("margin low");
  chk_high_go: assert property (marginHighGo == $past(chHit ? {w[1], w[5], w[9], w[13]} : 4'h0))
    else $error("margin high");
  chk_run_bits: assert property (wavegenRun == $past(chHit ? {w[0], w[4], w[8], w[12]} : wavegenRun))
    else $error("run bits");
  chk_wo_zero: assert property (s_rd_ch |=> (regRdata & 16'hEEEE) == 16'h0000) else $error("write-only");
endmodule : ncr_sva
bind ncr_nvm_channel_trigger_regs ncr_sva #(.CHANNELS(CHANNELS)) chk (.clk_sys(clk_sys), .resetn(resetn),
  .access(access), .regRdata(regRdata), .regRvalid(regRvalid), .faultRowReadGo(faultRowReadGo),
  .nonvolProgramGo(nonvolProgramGo), .nonvolRestoreGo(nonvolRestoreGo), .compareClear(compareClear),
  .marginLowGo(marginLowGo), .marginHighGo(marginHighGo), .wavegenRun(wavegenRun));

// ---- testbench/ncr_nvm_channel_trigger_regs_tb_top.sv ----
`timescale 1ns/1ns
module ncr_nvm_channel_trigger_regs_tb_top
  import ncr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic windowLatchEn = 1'b0;
  logic [3:0] cmpRawIn = 4'h0;
  logic [3:0] winRawIn = 4'h0;
  ncr_acc_s access;
  logic [15:0] regRdata;
  logic regRvalid;
  logic [3:0] cmpFlag;
  logic [3:0] winCmp;
  logic [15:0] run;
  logic [15:0] expQ[$];
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 16;
  initial forever #5 clk_sys = ~clk_sys;
  ncr_host_model host (.clk_sys(clk_sys), .access(access));
  ncr_nvm_channel_trigger_regs dut (.clk_sys(clk_sys), .resetn(resetn), .access(access),
    .windowLatchEn(windowLatchEn), .cmpRawIn(cmpRawIn), .winRawIn(winRawIn), .regRdata(regRdata),
    .regRvalid(regRvalid), .faultRowReadGo(), .nonvolProgramGo(), .nonvolRestoreGo(), .compareClear(),
    .marginLowGo(), .marginHighGo(), .wavegenRun(), .cmpFlag(cmpFlag), .winCmp(winCmp));
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // comparator flags and window outputs against the expected nibbles
  task automatic cmp_flags(input string n, input logic [7:0] e);
    cmp(n, {8'h00, e}, {8'h00, cmpFlag, winCmp});
  endtask : cmp_flags
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  // note the expected word, then issue the read
  task automatic rd(input logic p, input logic [7:0] g, input logic [7:0] a, input logic [15:0] e);
    expQ.push_back(e);
    host.xfer(1'b0, p, g, a, 16'h0000);
  endtask : rd
  // read answers checked against the oldest note; cycle ceiling
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 3000) begin
      errors++;
      complete_run();
    end else if (regRvalid === 1'b1) begin
      cmp("read data", expQ.pop_front(), regRdata);
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(1'b0, 8'h00, 8'h21, 16'h0000);
    rd(1'b0, 8'h00, 8'h3C, 16'h0000);
    repeat (8) begin
      run = 16'($random(seed));
      host.xfer(1'b1, 1'b0, 8'h00, 8'h21, run);
      rd(1'b0, 8'h00, 8'h21, run & 16'h1111);
      rd(1'b1, 8'hFF, 8'hE5, run & 16'h1111);
      rd(1'b1, 8'h3A, 8'hE5, 16'h0000);
    end
    $display("test channel register done");
    host.xfer(1'b1, 1'b1, 8'hFF, 8'hE4, 16'h0007);
    rd(1'b0, 8'h00, 8'h20, 16'h0000);
    $display("test nvm triggers done");
    windowLatchEn <= 1'b1;
    cmpRawIn <= 4'hF;
    winRawIn <= 4'hF;
    repeat (5) @(posedge clk_sys);
    cmpRawIn <= 4'h0;
    winRawIn <= 4'h0;
    repeat (5) @(posedge clk_sys);
    cmp_flags("flags held", 8'hFF);
    host.xfer(1'b1, 1'b0, 8'h00, 8'h21, 16'h8888);
    repeat (2) @(posedge clk_sys);
    cmp_flags("flags cleared", 8'h00);
    cmpRawIn <= 4'h1;
    host.xfer(1'b1, 1'b0, 8'h00, 8'h21, 16'h8888);
    repeat (2) @(posedge clk_sys);
    cmp_flags("set wins", 8'h10);
    cmpRawIn <= 4'h0;
    $display("test comparator clear done");
    windowLatchEn <= 1'b0;
    winRawIn <= 4'hF;
    repeat (4) @(posedge clk_sys);
    cmp_flags("window follows", 8'h1F);
    winRawIn <= 4'h0;
    repeat (4) @(posedge clk_sys);
    cmp_flags("window released", 8'h10);
    $display("test transparent window done");
    cmp("reads left", 16'h0000, 16'(expQ.size()));
    complete_run();
  end
endmodule : ncr_nvm_channel_trigger_regs_tb_top
